// ==== shared/pixel_pipe_pkg.sv ====
// Constants, register map and types of the pixel correction pipeline.
// Assumes one pixel clock domain shared by all users of the package.
package pixel_pipe_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int PIX_W     = 12;
	localparam int COORD_W   = 12;
	localparam int GAIN_W    = 10;
	localparam int GAIN_FRAC = 5;
	localparam int BLACK_W   = 8;
	localparam int ADDR_W    = 12;

	// ------------------------------------------------------------
	// Register map and reset values
	// ------------------------------------------------------------
	localparam logic [ADDR_W-1:0] CONTROL_ADDR = 12'h000;
	localparam logic [ADDR_W-1:0] GAIN_ADDR    = 12'h004;
	localparam logic [ADDR_W-1:0] BLACK_ADDR   = 12'h008;
	localparam logic [ADDR_W-1:0] DEFECT_ADDR  = 12'h00C;
	localparam logic [ADDR_W-1:0] STATUS_ADDR  = 12'h010;

	localparam logic               CONTROL_RESET = 1'b1;
	localparam logic [GAIN_W-1:0]  GAIN_RESET    = 10'h020;
	localparam logic [GAIN_W-1:0]  GAIN_MIN      = 10'h020;
	localparam logic [GAIN_W-1:0]  GAIN_MAX      = 10'h3C0;
	localparam logic [BLACK_W-1:0] BLACK_RESET   = 8'h00;
	localparam logic [31:0]        DEFECT_RESET  = 32'h00000000;

	// Defect entry word fields
	localparam int DEF_X_LSB  = 0;
	localparam int DEF_Y_LSB  = 12;
	localparam int DEF_IX_LSB = 24;
	localparam int DEF_ON_BIT = 31;
	// Status word fields
	localparam int STAT_LVL_LSB = 0;
	localparam int STAT_ROW_LSB = 16;

	// ------------------------------------------------------------
	// Defect list
	// ------------------------------------------------------------
	localparam int USER_SLOTS    = 8;
	localparam int USER_IX_W     = 3;
	localparam int FACTORY_COUNT = 2;
	localparam logic [COORD_W-1:0] FACTORY_X [FACTORY_COUNT] =
		'{12'h010, 12'h020};
	localparam logic [COORD_W-1:0] FACTORY_Y [FACTORY_COUNT] =
		'{12'h004, 12'h008};

	// ------------------------------------------------------------
	// Window and buffering
	// ------------------------------------------------------------
	localparam int         WIN          = 7;
	localparam int         CENTER       = 3;
	localparam logic [1:0] FLUSH_CYCLES = 2'h3;
	localparam int         FIFO_DEPTH   = 16;
	localparam int         FIFO_W       = PIX_W + 2;
	localparam int         FIFO_LVL_W   = 5;
	localparam logic [FIFO_LVL_W-1:0] FIFO_ADMIT = 5'h03;

	typedef enum logic [1:0] {
		ST_RUN   = 2'b01,
		ST_FLUSH = 2'b10
	} stream_state_t;

endpackage

// ==== shared/pixel_fifo_if.sv ====
// Carrier between the pipeline and its output FIFO.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface pixel_fifo_if #(parameter int W = 14, parameter int LW = 5);
	logic          in_valid;
	logic          in_ready;
	logic [W-1:0]  in_data;
	logic          out_valid;
	logic          out_ready;
	logic [W-1:0]  out_data;
	logic [LW-1:0] level;

	modport fifo (input in_valid, in_data, out_ready,
		output in_ready, out_valid, out_data, level);
	modport user (output in_valid, in_data, out_ready,
		input in_ready, out_valid, out_data, level);
endinterface
`default_nettype wire

// ==== hw/pixel_fifo.sv ====
// Synchronous FIFO with a registered output word.
// Assumes one clock; width and depth set by parameters.
`timescale 1ns/1ps
`default_nettype none
module pixel_fifo #(
	parameter int W = 14,
	parameter int D = 16
) (
	input  wire logic clock,
	input  wire logic reset,
	pixel_fifo_if.fifo port
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW:0]  wr_ptr;
	logic [AW:0]  rd_ptr;
	logic [AW:0]  count;
	logic         push;
	logic         load;

	assign count         = wr_ptr - rd_ptr;
	assign port.in_ready = (count != (AW+1)'(D));
	assign port.level    = count;
	assign push          = port.in_valid & port.in_ready;
	assign load          = (count != '0) &
		(~port.out_valid | port.out_ready);

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= port.in_data;
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (load) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end

	// Output register: holds its word until the sink takes it
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			port.out_valid <= 1'b0;
			port.out_data  <= '0;
		end else begin
			port.out_valid <= load | (port.out_valid & ~port.out_ready);
			if (load) begin
				port.out_data <= mem[rd_ptr[AW-1:0]];
			end
		end
	end
endmodule
`default_nettype wire

// ==== hw/pixel_correction_pipeline.sv ====
// Pixel correction pipeline: defect replacement, gain, black level.
// Assumes the pixel stream and the APB master run on this clock.
//
// Summary of operation
// R1 - Replace only from same-line good neighbours
// R2 - Mean of first neighbours, else good one
// R3 - Both first bad: use second neighbours likewise
// R4 - First, second bad: use third neighbours likewise
// R5 - Enable bit; when off defects pass unchanged
// R6 - Factory defect list plus user-entered coordinates
// R7 - Digital gain from 1.0x to 30.0x
// R8 - Add black level offset 0 to 255
// R9 - Uncovered or edge cases pass original value
// R10 - Gain and offset results saturate at maximum
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module pixel_correction_pipeline
	import pixel_pipe_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              in_valid,
	input  wire logic [PIX_W-1:0]  in_data,
	input  wire logic              in_frame_start,
	input  wire logic              in_line_start,
	input  wire logic              in_line_end,
	output logic                   in_ready,
	output logic                   out_valid,
	output logic      [PIX_W-1:0]  out_data,
	output logic                   out_frame_start,
	output logic                   out_line_start,
	input  wire logic              out_ready
);

	// ------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------
	logic               correct_enable;
	logic [GAIN_W-1:0]  gain;
	logic [BLACK_W-1:0] black_level;
	logic [31:0]        defect_word;
	logic [COORD_W-1:0] user_x [USER_SLOTS];
	logic [COORD_W-1:0] user_y [USER_SLOTS];
	logic               user_on [USER_SLOTS];
	logic [COORD_W-1:0] row;
	logic               setup;
	logic               wr_en;
	logic [GAIN_W-1:0]  wr_gain;
	logic [USER_IX_W-1:0] wr_ix;

	pixel_fifo_if #(.W(FIFO_W), .LW(FIFO_LVL_W)) fifo_port ();

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = (a == CONTROL_ADDR) || (a == GAIN_ADDR) ||
			(a == BLACK_ADDR) || (a == DEFECT_ADDR) ||
			(a == STATUS_ADDR);
	endfunction

	assign setup   = psel & ~penable;
	assign wr_en   = psel & penable & pready & pwrite;
	assign wr_gain = pwdata[GAIN_W-1:0];
	assign wr_ix   = pwdata[DEF_IX_LSB +: USER_IX_W];

	// Answer in the first access cycle; read data taken then
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~mapped(paddr);
			if (setup) begin
				prdata <= '0;
				case (paddr)
				CONTROL_ADDR: prdata[0] <= correct_enable;
				GAIN_ADDR:    prdata[GAIN_W-1:0] <= gain;
				BLACK_ADDR:   prdata[BLACK_W-1:0] <= black_level;
				DEFECT_ADDR:  prdata <= defect_word;
				STATUS_ADDR: begin
					prdata[STAT_LVL_LSB +: FIFO_LVL_W] <= fifo_port.level;
					prdata[STAT_ROW_LSB +: COORD_W]    <= row;
				end
				default:      prdata <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			correct_enable <= CONTROL_RESET;
			gain           <= GAIN_RESET;
			black_level    <= BLACK_RESET;
		end else if (wr_en) begin
			if (paddr == CONTROL_ADDR) begin
				correct_enable <= pwdata[0]; // [R5]
			end
			// Gain is clamped into the 1.0x..30.0x span
			if (paddr == GAIN_ADDR) begin
				if (wr_gain < GAIN_MIN) begin
					gain <= GAIN_MIN; // [R7]
				end else if (wr_gain > GAIN_MAX) begin
					gain <= GAIN_MAX; // [R7]
				end else begin
					gain <= wr_gain; // [R7]
				end
			end
			if (paddr == BLACK_ADDR) begin
				black_level <= pwdata[BLACK_W-1:0]; // [R8]
			end
		end
	end

	// User defect coordinates, one slot per write
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			defect_word <= DEFECT_RESET;
			for (int i = 0; i < USER_SLOTS; i++) begin
				user_x[i]  <= '0;
				user_y[i]  <= '0;
				user_on[i] <= 1'b0;
			end
		end else if (wr_en && paddr == DEFECT_ADDR) begin
			defect_word     <= pwdata;
			user_x[wr_ix]   <= pwdata[DEF_X_LSB +: COORD_W]; // [R6]
			user_y[wr_ix]   <= pwdata[DEF_Y_LSB +: COORD_W]; // [R6]
			user_on[wr_ix]  <= pwdata[DEF_ON_BIT]; // [R6]
		end
	end

	// ------------------------------------------------------------
	// Input side: coordinates and defect lookup
	// ------------------------------------------------------------
	logic               accept;
	logic [COORD_W-1:0] col;
	logic [COORD_W-1:0] cur_x;
	logic [COORD_W-1:0] cur_y;
	logic               cur_bad;
	logic               line_tag;

	assign accept = in_valid & in_ready;
	assign cur_x  = in_line_start ? '0 : col + 1'b1;
	assign cur_y  = in_frame_start ? '0 :
		(in_line_start ? row + 1'b1 : row);

	always_comb begin
		cur_bad = 1'b0;
		for (int i = 0; i < FACTORY_COUNT; i++) begin
			if (cur_x == FACTORY_X[i] && cur_y == FACTORY_Y[i]) begin
				cur_bad = 1'b1; // [R6]
			end
		end
		for (int i = 0; i < USER_SLOTS; i++) begin
			if (user_on[i] && cur_x == user_x[i] &&
				cur_y == user_y[i]) begin
				cur_bad = 1'b1; // [R6]
			end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			col      <= '0;
			row      <= '0;
			line_tag <= 1'b0;
		end else if (accept) begin
			col <= cur_x;
			row <= cur_y;
			if (in_line_start) begin
				line_tag <= ~line_tag;
			end
		end
	end

	// ------------------------------------------------------------
	// Line-end flush: bubbles push the last pixels to the centre
	// ------------------------------------------------------------
	stream_state_t state;
	stream_state_t next_state;
	logic [1:0]    flush_left;
	logic [1:0]    next_flush_left;
	logic          bubble;
	logic          shift;

	assign bubble = (state == ST_FLUSH);
	assign shift  = accept | bubble;

	always_comb begin
		next_state      = state;
		next_flush_left = flush_left;
		case (state)
		ST_RUN: begin
			if (accept && in_line_end) begin
				next_state      = ST_FLUSH;
				next_flush_left = FLUSH_CYCLES;
			end
		end
		ST_FLUSH: begin
			next_flush_left = flush_left - 1'b1;
			if (flush_left == 2'h1) begin
				next_state = ST_RUN;
			end
		end
		default: begin
			next_state      = ST_RUN;
			next_flush_left = '0;
		end
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			state      <= ST_RUN;
			flush_left <= '0;
			in_ready   <= 1'b0;
		end else begin
			state      <= next_state;
			flush_left <= next_flush_left;
			in_ready   <= (next_state == ST_RUN) &&
				(fifo_port.level < FIFO_ADMIT);
		end
	end

	// ------------------------------------------------------------
	// Seven-pixel line window; slot 0 is newest (rightmost)
	// ------------------------------------------------------------
	logic [PIX_W-1:0] win_px  [WIN];
	logic             win_ok  [WIN];
	logic             win_bad [WIN];
	logic             win_tag [WIN];
	logic             win_sof [WIN];
	logic             win_sol [WIN];
	logic             fresh;

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			fresh <= 1'b0;
			for (int i = 0; i < WIN; i++) begin
				win_px[i]  <= '0;
				win_ok[i]  <= 1'b0;
				win_bad[i] <= 1'b0;
				win_tag[i] <= 1'b0;
				win_sof[i] <= 1'b0;
				win_sol[i] <= 1'b0;
			end
		end else begin
			fresh <= shift;
			if (shift) begin
				win_px[0]  <= in_data;
				win_ok[0]  <= accept;
				win_bad[0] <= cur_bad;
				win_tag[0] <= in_line_start ? ~line_tag : line_tag;
				win_sof[0] <= in_frame_start;
				win_sol[0] <= in_line_start;
				for (int i = 1; i < WIN; i++) begin
					win_px[i]  <= win_px[i-1];
					win_ok[i]  <= win_ok[i-1];
					win_bad[i] <= win_bad[i-1];
					win_tag[i] <= win_tag[i-1];
					win_sof[i] <= win_sof[i-1];
					win_sol[i] <= win_sol[i-1];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Replacement value for the centre pixel
	// ------------------------------------------------------------
	logic [PIX_W-1:0] fixed_px;

	always_comb begin
		logic          done;
		logic          l_ok;
		logic          r_ok;
		logic          l_bad;
		logic          r_bad;
		logic [PIX_W:0] sum;
		done     = 1'b0;
		l_ok     = 1'b0;
		r_ok     = 1'b0;
		l_bad    = 1'b0;
		r_bad    = 1'b0;
		sum      = '0;
		fixed_px = win_px[CENTER];
		if (correct_enable && win_bad[CENTER]) begin // [R5]
			for (int k = 1; k <= CENTER; k++) begin
				// Neighbours from another line count as absent
				l_ok  = win_ok[CENTER+k] &&
					win_tag[CENTER+k] == win_tag[CENTER]; // [R1]
				r_ok  = win_ok[CENTER-k] &&
					win_tag[CENTER-k] == win_tag[CENTER]; // [R1]
				l_bad = win_bad[CENTER+k];
				r_bad = win_bad[CENTER-k];
				sum   = {1'b0, win_px[CENTER+k]} +
					{1'b0, win_px[CENTER-k]};
				if (!done) begin
					if (!(l_ok && r_ok)) begin
						done = 1'b1; // [R9]
					end else if (!l_bad && !r_bad) begin
						fixed_px = sum[PIX_W:1]; // [R2] [R3] [R4]
						done     = 1'b1;
					end else if (l_bad && !r_bad) begin
						fixed_px = win_px[CENTER-k]; // [R2] [R3] [R4]
						done     = 1'b1;
					end else if (!l_bad && r_bad) begin
						fixed_px = win_px[CENTER+k]; // [R2] [R3] [R4]
						done     = 1'b1;
					end
				end
			end
		end
	end

	// ------------------------------------------------------------
	// Gain and black level, both saturating
	// ------------------------------------------------------------
	localparam int PROD_W = PIX_W + GAIN_W;
	localparam logic [PIX_W-1:0] PIX_MAX = 12'hFFF;

	logic [PIX_W-1:0]  c_px;
	logic              c_valid;
	logic [1:0]        c_flags;
	logic [PIX_W-1:0]  g_px;
	logic              g_valid;
	logic [1:0]        g_flags;
	logic [PIX_W-1:0]  o_px;
	logic              o_valid;
	logic [1:0]        o_flags;
	logic [PROD_W-1:0] prod;
	logic [PIX_W:0]    offs_sum;

	assign prod     = PROD_W'(c_px) * PROD_W'(gain);
	assign offs_sum = {1'b0, g_px} + (PIX_W+1)'(black_level);

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			c_valid <= 1'b0;
			c_px    <= '0;
			c_flags <= '0;
			g_valid <= 1'b0;
			g_px    <= '0;
			g_flags <= '0;
			o_valid <= 1'b0;
			o_px    <= '0;
			o_flags <= '0;
		end else begin
			c_valid <= fresh & win_ok[CENTER];
			c_px    <= fixed_px;
			c_flags <= {win_sof[CENTER], win_sol[CENTER]};
			g_valid <= c_valid;
			g_flags <= c_flags;
			if (|prod[PROD_W-1:GAIN_FRAC+PIX_W]) begin
				g_px <= PIX_MAX; // [R7] [R10]
			end else begin
				g_px <= prod[GAIN_FRAC +: PIX_W]; // [R7]
			end
			o_valid <= g_valid;
			o_flags <= g_flags;
			if (offs_sum[PIX_W]) begin
				o_px <= PIX_MAX; // [R8] [R10]
			end else begin
				o_px <= offs_sum[PIX_W-1:0]; // [R8]
			end
		end
	end

	// ------------------------------------------------------------
	// Output FIFO; admission limit in in_ready keeps it from overflow
	// ------------------------------------------------------------
	assign fifo_port.in_valid  = o_valid;
	assign fifo_port.in_data   = {o_flags, o_px};
	assign fifo_port.out_ready = out_ready;

	pixel_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) out_fifo (
		.clock (clock),
		.reset (reset),
		.port  (fifo_port)
	);

	assign out_valid       = fifo_port.out_valid;
	assign out_data        = fifo_port.out_data[PIX_W-1:0];
	assign out_line_start  = fifo_port.out_data[PIX_W];
	assign out_frame_start = fifo_port.out_data[PIX_W+1];

endmodule
`default_nettype wire

// ==== verification/pixel_pipe_monitor.sv ====
// Port checker for the pixel correction pipeline.
// Assumes one clock and an active-high asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module pixel_pipe_monitor
	import pixel_pipe_pkg::*;
(
	input wire logic              clock,
	input wire logic              reset,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [31:0]       prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire logic              in_valid,
	input wire logic              in_ready,
	input wire logic              in_line_end,
	input wire logic              out_valid,
	input wire logic              out_ready,
	input wire logic [PIX_W-1:0]  out_data,
	input wire logic              out_frame_start,
	input wire logic              out_line_start
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);

	// ------------------------------------------------------------
	// Shadow of the black level register
	// ------------------------------------------------------------
	logic [BLACK_W-1:0] blk;
	wire logic          acc = psel && penable && pready;

	always_ff @(posedge clock or posedge reset) begin
		if (reset)
			blk <= BLACK_RESET;
		else if (acc && pwrite && paddr == BLACK_ADDR)
			blk <= pwdata[BLACK_W-1:0];
	end

	sequence setup_s;
		psel && !penable;
	endsequence
	sequence line_done_s;
		in_valid && in_ready && in_line_end;
	endsequence

	chk_ready_access:
		assert property (setup_s |=> pready)
		else $error("pready missing in access cycle");
	chk_ready_pulse:
		assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_unmapped_err:
		assert property (acc && paddr > STATUS_ADDR |-> pslverr)
		else $error("unmapped address not refused");
	chk_err_data_zero:
		assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response malformed");
	chk_gain_range:
		assert property (acc && !pwrite && paddr == GAIN_ADDR |->
			prdata[9:0] >= GAIN_MIN && prdata[9:0] <= GAIN_MAX)
		else $error("gain outside 1.0 to 30.0");
	chk_black_floor:
		assert property (out_valid |-> out_data >= PIX_W'(blk))
		else $error("output below black level");
	chk_out_hold:
		assert property (out_valid && !out_ready |=>
			out_valid && $stable(out_data))
		else $error("output word not held");
	chk_line_flush:
		assert property (line_done_s |-> ##[1:2] !in_ready)
		else $error("no flush after line end");
	chk_frame_line:
		assert property (out_valid && out_frame_start |-> out_line_start)
		else $error("frame start without line start");
endmodule

bind pixel_correction_pipeline pixel_pipe_monitor pixel_pipe_monitor_inst (.*);
`default_nettype wire

// ==== verification/pixel_stream_partner.sv ====
// Sensor readout source and video output sink.
// Assumes the bench calls send and idle right after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module pixel_stream_partner
	import pixel_pipe_pkg::*;
(
	input  wire logic             clock,
	output logic                  in_valid,
	output logic      [PIX_W-1:0] in_data,
	output logic                  in_frame_start,
	output logic                  in_line_start,
	output logic                  in_line_end,
	input  wire logic             in_ready,
	input  wire logic             out_valid,
	input  wire logic [PIX_W-1:0] out_data,
	input  wire logic             out_frame_start,
	input  wire logic             out_line_start,
	output logic                  out_ready
);
	logic [13:0] got [$];
	logic [1:0]  cnt = 2'h0;
	int          stall = 40;

	initial begin
		{in_valid, in_frame_start, in_line_start, in_line_end} = 4'h0;
		in_data = 12'h000;
		out_ready = 1'b0;
	end

	// Sink: holds off while the first words wait, then stalls 1 in 4
	always @(posedge clock) begin
		if (out_valid && out_ready)
			got.push_back({out_frame_start, out_line_start, out_data});
		if (stall > 0 && out_valid)
			stall <= stall - 1;
		out_ready <= stall == 0 && cnt != 2'h2;
		cnt <= cnt + 2'h1;
	end

	task send(input logic [PIX_W-1:0] d, input logic fs, ls, le);
		in_valid <= 1'b1;
		in_data <= d;
		in_frame_start <= fs;
		in_line_start <= ls;
		in_line_end <= le;
		@(posedge clock);
		while (in_ready !== 1'b1)
			@(posedge clock);
	endtask

	// Released data lines show the inverse of the last pixel
	task idle;
		in_valid <= 1'b0;
		in_data <= ~in_data;
		{in_frame_start, in_line_start, in_line_end} <= 3'h0;
	endtask
endmodule
`default_nettype wire

// ==== verification/pixel_correction_pipeline_tb.sv ====
// Bench for the pixel correction pipeline.
// Assumes the checker is bound and the partner model is compiled.
`timescale 1ns/1ps
`default_nettype none
module pixel_correction_pipeline_tb
	import pixel_pipe_pkg::*;
;
	logic              clock = 1'b0;
	logic              reset = 1'b1;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = 12'h000;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       r;
	logic              err;
	wire  [31:0]       prdata;
	wire               pready, pslverr, in_ready, out_valid, out_ready;
	wire               in_valid, in_frame_start, in_line_start;
	wire               in_line_end, out_frame_start, out_line_start;
	wire  [PIX_W-1:0]  in_data, out_data;
	int                n_mismatch, comparisons, cyc, g, b;
	logic [PIX_W-1:0]  pix [32];
	int                defx [8] = '{0, 5, 14, 15, 17, 18, 25, 26};
	bit                bad [32];

	pixel_correction_pipeline pixel_correction_pipeline_inst (.*);
	pixel_stream_partner pixel_stream_partner_inst (.*);

	always #10 clock = ~clock;

	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// Bus tasks and reference model
	// ------------------------------------------------------------
	task stop_test;
		if (n_mismatch == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task cmp(input logic [31:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		while (pready !== 1'b1)
			@(posedge clock);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		cmp(r, e);
	endtask

	// Nearest good pair at levels 1 to 3; edge or all bad keeps original
	function automatic int fix(int x);
		for (int k = 1; k <= 3; k++) begin
			if (x - k < 0 || x + k > 31 || !bad[x])
				return pix[x];
			if (!bad[x - k] && !bad[x + k])
				return (int'(pix[x - k]) + int'(pix[x + k])) / 2;
			if (!bad[x - k])
				return pix[x - k];
			if (!bad[x + k])
				return pix[x + k];
		end
		return pix[x];
	endfunction

	function automatic int oval(int p);
		int v;
		v = p * g / 32;
		v = (v > 4095) ? 4095 : v;
		v = v + b;
		return (v > 4095) ? 4095 : v;
	endfunction

	task automatic frame(input bit en);
		logic [13:0] q [$];
		for (int y = 0; y < 5; y++) begin
			for (int x = 0; x < 32; x++) begin
				pix[x] = 12'(x * 131 + y * 7);
				bad[x] = en && y == 4 &&
					x inside {0, 5, 14, 15, 16, 17, 18, 25, 26};
			end
			for (int x = 0; x < 32; x++)
				q.push_back({x == 0 && y == 0, x == 0, 12'(oval(fix(x)))});
			for (int x = 0; x < 32; x++)
				pixel_stream_partner_inst.send(pix[x], x == 0 && y == 0,
					x == 0, x == 31);
		end
		pixel_stream_partner_inst.idle();
		while (pixel_stream_partner_inst.got.size() < q.size())
			@(posedge clock);
		foreach (q[i])
			cmp(32'(pixel_stream_partner_inst.got[i]), 32'(q[i]));
		pixel_stream_partner_inst.got.delete();
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		rd(CONTROL_ADDR, 32'h1);
		rd(GAIN_ADDR, 32'h20);
		wr(GAIN_ADDR, 32'h3FF);
		rd(GAIN_ADDR, 32'h3C0);
		wr(GAIN_ADDR, 32'h40);
		wr(BLACK_ADDR, 32'h10);
		rd(BLACK_ADDR, 32'h10);
		foreach (defx[i])
			wr(DEFECT_ADDR, {1'b1, 4'h0, 3'(i), 12'h004,
				12'(defx[i])});
		rd(DEFECT_ADDR, 32'h8700401A);
		rd(12'h014, 32'h0);
		cmp({31'h0, err}, 32'h1);
		g = 64;
		b = 16;
		frame(1'b1);
		rd(STATUS_ADDR, 32'h00040000);
		wr(CONTROL_ADDR, 32'h0);
		wr(GAIN_ADDR, 32'h1);
		rd(GAIN_ADDR, 32'h20);
		wr(BLACK_ADDR, 32'hFF);
		g = 32;
		b = 255;
		frame(1'b0);
		stop_test();
	end
endmodule
`default_nettype wire
